// [inc/pfsc_pkg.sv]
// Purpose: constants and carriers for the pin function and strobe block
// Assumes: one clock at 50 MHz, each clock stands for one oscillator period
// Notes: register map is word aligned on an AXI4-Lite slave
package pfsc_pkg;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 20;
	localparam int ALE_PERIOD = 6;
	localparam int RST_PULSE_NS = 480;
	localparam int RST_PULSE_CYC =
		(RST_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ----------------------------------------------------------------
	// register offsets (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_LATCH0 = 8'h00;
	localparam logic [7:0] OFS_LATCH1 = 8'h04;
	localparam logic [7:0] OFS_LATCH2 = 8'h08;
	localparam logic [7:0] OFS_LATCH3 = 8'h0c;
	localparam logic [7:0] OFS_LATCH4 = 8'h10;
	localparam logic [7:0] OFS_PIN0 = 8'h20;
	localparam logic [7:0] OFS_PIN1 = 8'h24;
	localparam logic [7:0] OFS_PIN2 = 8'h28;
	localparam logic [7:0] OFS_PIN3 = 8'h2c;
	localparam logic [7:0] OFS_PIN4 = 8'h30;
	localparam logic [7:0] OFS_PIN5 = 8'h34;
	localparam logic [7:0] OFS_CANCTL = 8'h40;
	localparam logic [7:0] OFS_STATUS = 8'h44;
	localparam logic [7:0] OFS_ADCCMD = 8'h48;

	// ----------------------------------------------------------------
	// fields and reset values
	// ----------------------------------------------------------------
	localparam int CR_CAN_RESET = 0;
	localparam int CR_REF_DIR = 5;
	localparam logic [7:0] CR_RESET_VAL = 8'h01;
	localparam logic [7:0] CR_MASK = 8'h21;
	localparam logic [7:0] LATCH_RESET_VAL = 8'hff;
	localparam int ST_EA = 0;
	localparam int ST_CANRX = 1;
	localparam int ST_REFSRC = 2;
	localparam int ADC_SW_START = 0;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ----------------------------------------------------------------
	// carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [7:0] out;
		logic [7:0] oe_b;
	} pfsc_pin8_t;

	typedef struct packed {
		logic active;
		logic xdata;
		logic addr_phase;
		logic write;
		logic [15:0] addr;
		logic [7:0] wdata;
	} pfsc_mem_t;

	typedef struct packed {
		logic [7:0] p0;
		logic [7:0] p1;
		logic [7:0] p2;
		logic [7:0] p3;
		logic [7:0] p4;
		logic [7:0] p5;
		logic adc_start;
		logic ea;
		logic rst_pin;
		logic can_cmp;
	} pfsc_pins_in_t;

	// idle pin levels: pulled-up ports high, receive recessive
	localparam pfsc_pins_in_t PINS_IDLE = '{p0: 8'hff, p1: 8'hff,
		p2: 8'hff, p3: 8'hff, p4: 8'hff, p5: 8'h00, adc_start: 1'b0,
		ea: 1'b1, rst_pin: 1'b0, can_cmp: 1'b1};

	typedef struct packed {
		logic [5:0] cmp_set_reset;
		logic [1:0] cmp_toggle;
		logic serial_tx;
		logic wr_strobe_b;
		logic rd_strobe_b;
		logic can_tx0;
		logic can_tx1;
	} pfsc_alt_out_t;

	typedef struct packed {
		logic [3:0] capture_irq;
		logic timer_event;
		logic timer_reset;
		logic serial_rx;
		logic irq_zero_b;
		logic irq_one_b;
		logic counter0;
		logic counter1;
	} pfsc_alt_in_t;

endpackage : pfsc_pkg

// [hw/pfsc_top.sv]
// Purpose: port pin functions, memory strobes, reset pin and CAN pin control
// Assumes: pin levels arrive asynchronously and are synchronised here
// Notes: oe_b low means the pin is driven; released pins read high
//
// The implementer's own choices: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ns
module pfsc_top
#(
	parameter int ADDR_W = 8
)
(
	input wire logic clock_i,
	input wire logic rst_b_i,
	input wire logic [ADDR_W-1:0] s_axi_awaddr_i,
	input wire logic s_axi_awvalid_i,
	output logic s_axi_awready_o,
	input wire logic [31:0] s_axi_wdata_i,
	input wire logic [3:0] s_axi_wstrb_i,
	input wire logic s_axi_wvalid_i,
	output logic s_axi_wready_o,
	output logic [1:0] s_axi_bresp_o,
	output logic s_axi_bvalid_o,
	input wire logic s_axi_bready_i,
	input wire logic [ADDR_W-1:0] s_axi_araddr_i,
	input wire logic s_axi_arvalid_i,
	output logic s_axi_arready_o,
	output logic [31:0] s_axi_rdata_o,
	output logic [1:0] s_axi_rresp_o,
	output logic s_axi_rvalid_o,
	input wire logic s_axi_rready_i,
	input wire pfsc_pkg::pfsc_pins_in_t pins_i,
	input wire pfsc_pkg::pfsc_mem_t mem_i,
	input wire pfsc_pkg::pfsc_alt_out_t alt_i,
	input wire logic watchdog_overflow_i,
	input wire logic can_wake_i,
	input wire logic power_down_i,
	output pfsc_pkg::pfsc_pin8_t port0_o,
	output pfsc_pkg::pfsc_pin8_t port1_o,
	output pfsc_pkg::pfsc_pin8_t port2_o,
	output pfsc_pkg::pfsc_pin8_t port3_o,
	output pfsc_pkg::pfsc_pin8_t port4_o,
	output pfsc_pkg::pfsc_alt_in_t alt_o,
	output logic [7:0] ext_rdata_o,
	output logic [7:0] analog_channels_o,
	output logic ale_o,
	output logic rst_pin_out_o,
	output logic rst_pin_oe_b_o,
	output logic conv_start_o,
	output logic ea_latched_o,
	output logic can_rx_bit_o,
	output logic can_reset_o,
	output logic ref_oe_b_o,
	output logic ref_src_en_o
);
	import pfsc_pkg::*;

	if (ADDR_W < 7)
	begin : g_chk
		$error("pfsc_top: ADDR_W too small for the register map");
	end

	// ----------------------------------------------------------------
	// synchronisers and edges
	// ----------------------------------------------------------------
	pfsc_pins_in_t meta_r;
	pfsc_pins_in_t sync_r;
	pfsc_pins_in_t prev_r;

	function automatic logic rise(input logic cur, input logic old);
		rise = cur & ~old;
	endfunction : rise

	always_ff @(posedge clock_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			// idle levels, so a pulled-up pin gives no edge after reset
			meta_r <= PINS_IDLE;
			sync_r <= PINS_IDLE;
			prev_r <= PINS_IDLE;
		end
		else
		begin
			meta_r <= pins_i;
			sync_r <= meta_r;
			prev_r <= sync_r;
		end
	end

	// ----------------------------------------------------------------
	// register bus
	// ----------------------------------------------------------------
	logic [7:0] latch_r [0:4];
	logic [7:0] cr_r;
	logic aw_got_r;
	logic w_got_r;
	logic [ADDR_W-1:0] awaddr_r;
	logic [7:0] wbyte_r;
	logic wlane_r;
	logic sw_start_r;
	logic [31:0] rd_mux;
	logic rd_hit;
	logic do_write;
	logic [3:0] wsel;

	function automatic logic [3:0] reg_sel(input logic [ADDR_W-1:0] a);
		logic [7:0] b;
		b = 8'(a);
		unique case (b)
			OFS_LATCH0: reg_sel = 4'h0;
			OFS_LATCH1: reg_sel = 4'h1;
			OFS_LATCH2: reg_sel = 4'h2;
			OFS_LATCH3: reg_sel = 4'h3;
			OFS_LATCH4: reg_sel = 4'h4;
			OFS_PIN0: reg_sel = 4'h5;
			OFS_PIN1: reg_sel = 4'h6;
			OFS_PIN2: reg_sel = 4'h7;
			OFS_PIN3: reg_sel = 4'h8;
			OFS_PIN4: reg_sel = 4'h9;
			OFS_PIN5: reg_sel = 4'ha;
			OFS_CANCTL: reg_sel = 4'hb;
			OFS_STATUS: reg_sel = 4'hc;
			OFS_ADCCMD: reg_sel = 4'hd;
			default: reg_sel = 4'hf;
		endcase
	endfunction : reg_sel

	assign do_write = aw_got_r & w_got_r & ~s_axi_bvalid_o;
	assign wsel = reg_sel(awaddr_r);

	always_ff @(posedge clock_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			aw_got_r <= 1'b0;
			w_got_r <= 1'b0;
			awaddr_r <= '0;
			wbyte_r <= 8'h00;
			wlane_r <= 1'b0;
			s_axi_awready_o <= 1'b0;
			s_axi_wready_o <= 1'b0;
			s_axi_bvalid_o <= 1'b0;
			s_axi_bresp_o <= RESP_OKAY;
		end
		else
		begin
			s_axi_awready_o <= ~aw_got_r & ~s_axi_awready_o;
			s_axi_wready_o <= ~w_got_r & ~s_axi_wready_o;
			if (s_axi_awvalid_i && s_axi_awready_o)
			begin
				aw_got_r <= 1'b1;
				awaddr_r <= s_axi_awaddr_i;
				s_axi_awready_o <= 1'b0;
			end
			if (s_axi_wvalid_i && s_axi_wready_o)
			begin
				w_got_r <= 1'b1;
				wbyte_r <= s_axi_wdata_i[7:0];
				wlane_r <= s_axi_wstrb_i[0];
				s_axi_wready_o <= 1'b0;
			end
			if (do_write)
			begin
				s_axi_bvalid_o <= 1'b1;
				s_axi_bresp_o <= (wsel == 4'hf) ? RESP_SLVERR : RESP_OKAY;
			end
			if (s_axi_bvalid_o && s_axi_bready_i)
			begin
				s_axi_bvalid_o <= 1'b0;
				aw_got_r <= 1'b0;
				w_got_r <= 1'b0;
			end
		end
	end

	// latches reset high so CAN transmit pins float at power-up
	always_ff @(posedge clock_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			for (int i = 0; i < 5; i++)
				latch_r[i] <= LATCH_RESET_VAL;
		end
		else if (do_write && wlane_r && wsel < 4'h5)
		begin
			latch_r[wsel[2:0]] <= wbyte_r;
		end
	end

	// external reset pin also returns CAN control to its reset value
	always_ff @(posedge clock_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			cr_r <= CR_RESET_VAL;
		else if (sync_r.rst_pin)
			cr_r <= CR_RESET_VAL;
		else if (do_write && wlane_r && wsel == 4'hb)
			cr_r <= wbyte_r & CR_MASK;
	end

	always_ff @(posedge clock_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			sw_start_r <= 1'b0;
		else
			sw_start_r <= do_write & wlane_r & (wsel == 4'hd) &
				wbyte_r[ADC_SW_START];
	end

	always_comb
	begin
		rd_hit = 1'b1;
		rd_mux = 32'h0000_0000;
		unique case (reg_sel(s_axi_araddr_i))
			4'h0: rd_mux[7:0] = latch_r[0];
			4'h1: rd_mux[7:0] = latch_r[1];
			4'h2: rd_mux[7:0] = latch_r[2];
			4'h3: rd_mux[7:0] = latch_r[3];
			4'h4: rd_mux[7:0] = latch_r[4];
			4'h5: rd_mux[7:0] = sync_r.p0;
			4'h6: rd_mux[7:0] = sync_r.p1;
			4'h7: rd_mux[7:0] = sync_r.p2;
			4'h8: rd_mux[7:0] = sync_r.p3;
			4'h9: rd_mux[7:0] = sync_r.p4;
			4'ha: rd_mux[7:0] = sync_r.p5;
			4'hb: rd_mux[7:0] = cr_r;
			4'hc:
			begin
				rd_mux[ST_EA] = ea_latched_o;
				rd_mux[ST_CANRX] = can_rx_bit_o;
				rd_mux[ST_REFSRC] = ref_src_en_o;
			end
			4'hd: rd_mux = 32'h0000_0000;
			default: rd_hit = 1'b0;
		endcase
	end

	always_ff @(posedge clock_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			s_axi_arready_o <= 1'b0;
			s_axi_rvalid_o <= 1'b0;
			s_axi_rdata_o <= 32'h0000_0000;
			s_axi_rresp_o <= RESP_OKAY;
		end
		else
		begin
			s_axi_arready_o <= ~s_axi_rvalid_o & ~s_axi_arready_o;
			if (s_axi_arvalid_i && s_axi_arready_o)
			begin
				s_axi_arready_o <= 1'b0;
				s_axi_rvalid_o <= 1'b1;
				s_axi_rdata_o <= rd_mux;
				s_axi_rresp_o <= rd_hit ? RESP_OKAY : RESP_SLVERR;
			end
			else if (s_axi_rvalid_o && s_axi_rready_i)
			begin
				s_axi_rvalid_o <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// address latch strobe
	// ----------------------------------------------------------------
	logic [2:0] ale_cnt_r;

	always_ff @(posedge clock_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			ale_cnt_r <= 3'h0;
			ale_o <= 1'b0;
		end
		else
		begin
			ale_cnt_r <= (ale_cnt_r == 3'(ALE_PERIOD - 1)) ?
				3'h0 : ale_cnt_r + 3'h1;
			ale_o <= (ale_cnt_r == 3'h0) & ~(mem_i.active & mem_i.xdata);
		end
	end

	// ----------------------------------------------------------------
	// reset pin pulse, access select latch, reference, CAN receive
	// ----------------------------------------------------------------
	logic [7:0] rst_cnt_r;

	always_ff @(posedge clock_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			rst_cnt_r <= 8'h00;
			rst_pin_out_o <= 1'b0;
			rst_pin_oe_b_o <= 1'b1;
		end
		else
		begin
			if (watchdog_overflow_i || can_wake_i)
				rst_cnt_r <= 8'(RST_PULSE_CYC);
			else if (rst_cnt_r != 8'h00)
				rst_cnt_r <= rst_cnt_r - 8'h01;
			rst_pin_out_o <= watchdog_overflow_i | can_wake_i |
				(rst_cnt_r > 8'h01);
			rst_pin_oe_b_o <= ~(watchdog_overflow_i | can_wake_i |
				(rst_cnt_r > 8'h01));
		end
	end

	// pin is only listened to while reset is asserted on it
	logic ea_r;
	always_ff @(posedge clock_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			ea_r <= 1'b1;
		else if (sync_r.rst_pin)
			ea_r <= sync_r.ea;
	end

	always_ff @(posedge clock_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			ea_latched_o <= 1'b1;
			can_rx_bit_o <= 1'b1;
			can_reset_o <= 1'b1;
			ref_oe_b_o <= 1'b0;
			ref_src_en_o <= 1'b1;
		end
		else
		begin
			ea_latched_o <= ea_r;
			// comparator high means positive line above negative
			can_rx_bit_o <= sync_r.can_cmp;
			can_reset_o <= cr_r[CR_CAN_RESET];
			ref_oe_b_o <= cr_r[CR_REF_DIR];
			ref_src_en_o <= ~cr_r[CR_REF_DIR] &
				~(cr_r[CR_CAN_RESET] & power_down_i);
		end
	end

	// ----------------------------------------------------------------
	// timer and converter triggers, alternate inputs
	// ----------------------------------------------------------------
	always_ff @(posedge clock_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			conv_start_o <= 1'b0;
			alt_o <= '0;
			analog_channels_o <= 8'h00;
			ext_rdata_o <= 8'h00;
		end
		else
		begin
			conv_start_o <= rise(sync_r.adc_start, prev_r.adc_start) |
				sw_start_r;
			alt_o.capture_irq <= sync_r.p1[3:0];
			alt_o.timer_event <= rise(sync_r.p1[4], prev_r.p1[4]);
			alt_o.timer_reset <= rise(sync_r.p1[5], prev_r.p1[5]);
			alt_o.serial_rx <= sync_r.p3[0];
			alt_o.irq_zero_b <= sync_r.p3[2];
			alt_o.irq_one_b <= sync_r.p3[3];
			alt_o.counter0 <= sync_r.p3[4];
			alt_o.counter1 <= sync_r.p3[5];
			analog_channels_o <= sync_r.p5;
			ext_rdata_o <= sync_r.p0;
		end
	end

	// ----------------------------------------------------------------
	// pin drivers
	// ----------------------------------------------------------------
	// quasi-bidirectional pins pull low only; a high bit releases the pin; bus cycles and CAN transmit out of reset drive both levels
	logic [7:0] eff1;
	logic [7:0] eff3;
	logic [7:0] eff4;
	logic [7:0] alt1;
	logic [7:0] alt3;
	logic [7:0] alt4;

	always_comb
	begin
		alt1 = {alt_i.can_tx1, alt_i.can_tx0, 6'h3f};
		alt3 = {alt_i.rd_strobe_b, alt_i.wr_strobe_b, 4'hf,
			alt_i.serial_tx, 1'b1};
		alt4 = {alt_i.cmp_toggle, alt_i.cmp_set_reset};
		eff1 = latch_r[1] & alt1;
		eff3 = latch_r[3] & alt3;
		eff4 = latch_r[4] & alt4;
	end

	always_ff @(posedge clock_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			port0_o <= {8'h00, 8'hff};
			port1_o <= {8'h00, 8'hff};
			port2_o <= {8'h00, 8'hff};
			port3_o <= {8'h00, 8'hff};
			port4_o <= {8'h00, 8'hff};
		end
		else
		begin
			if (mem_i.active && mem_i.addr_phase)
				port0_o <= {mem_i.addr[7:0], 8'h00};
			else if (mem_i.active && mem_i.write)
				port0_o <= {mem_i.wdata, 8'h00};
			else if (mem_i.active)
				port0_o <= {8'h00, 8'hff};
			else
				port0_o <= {8'h00, latch_r[0]};
			port1_o.out <= 8'h00;
			port1_o.oe_b[5:0] <= eff1[5:0];
			if (cr_r[CR_CAN_RESET])
			begin
				port1_o.oe_b[7:6] <= latch_r[1][7:6];
			end
			else
			begin
				port1_o.out[7:6] <= {alt_i.can_tx1, alt_i.can_tx0};
				port1_o.oe_b[7:6] <= 2'h0;
			end
			if (mem_i.active)
				port2_o <= {mem_i.addr[15:8], 8'h00};
			else
				port2_o <= {8'h00, latch_r[2]};
			port3_o <= {8'h00, eff3};
			port4_o <= {8'h00, eff4};
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (!rst_b_i);

	sequence s_p14_rise;
		!sync_r.p1[4] ##1 sync_r.p1[4];
	endsequence

	sequence s_ale_gap;
		!ale_o [*5];
	endsequence

	a_ale_spacing: assert property (ale_o |=> s_ale_gap)
		else $error("address strobe repeated too soon");
	a_ale_skip: assert property (
		(ale_cnt_r == 3'h0 && mem_i.active && mem_i.xdata) |=> !ale_o)
		else $error("address strobe not skipped");
	a_rst_pulse: assert property (
		(watchdog_overflow_i || can_wake_i) |=>
		(!rst_pin_oe_b_o && rst_pin_out_o) [*8])
		else $error("reset pin pulse missing or short");
	a_ea_hold: assert property (!sync_r.rst_pin |=> $stable(ea_r))
		else $error("access select changed outside reset");
	a_ref_dir: assert property (sync_r.rst_pin |=> ##1 !ref_oe_b_o)
		else $error("reference not output after external reset");
	a_ref_off: assert property (
		(cr_r[CR_CAN_RESET] && power_down_i) |=> !ref_src_en_o)
		else $error("half-supply source left on in power-down");
	a_can_float: assert property (
		(cr_r[CR_CAN_RESET] && latch_r[1][6]) |=> port1_o.oe_b[6])
		else $error("transmit pin driven while CAN in reset");
	a_tmr_event: assert property (s_p14_rise |=> alt_o.timer_event)
		else $error("timer event edge lost");
	a_conv_start: assert property (sw_start_r |=> conv_start_o)
		else $error("software conversion start lost");
	a_can_rx: assert property (
		##1 can_rx_bit_o == $past(sync_r.can_cmp))
		else $error("receive level misread");
	a_alt_gate: assert property (
		!latch_r[4][6] |=> !port4_o.oe_b[6])
		else $error("compare output not gated by latch");

endmodule : pfsc_top

// [bench/pfsc_ext_mem.sv]
// Purpose: external memory and board pull-ups on the multiplexed bus
// Assumes: port 0 pins have pull-ups, so a released pin reads high
// Notes: read data is a fixed pattern of the address, nothing is stored
`timescale 1ns/1ns
module pfsc_ext_mem
	import pfsc_pkg::*;
(
	input wire logic clock_i,
	input wire pfsc_pkg::pfsc_pin8_t port0_i,
	input wire pfsc_pkg::pfsc_pin8_t port2_i,
	input wire pfsc_pkg::pfsc_pin8_t port3_i,
	input wire logic ale_i,
	output logic [7:0] p0_level_o
);
	logic [7:0] lo_addr_r;
	logic rd_pin;
	logic [7:0] rd_data;

	// read strobe pin: released means pulled high
	assign rd_pin = port3_i.oe_b[7] ? 1'b1 : port3_i.out[7];
	assign rd_data = port2_i.out ^ lo_addr_r ^ 8'h5a;

	// device drive wins, memory answers a read, else the pull-up
	always_comb
	begin
		for (int i = 0; i < 8; i++)
		begin
			if (!port0_i.oe_b[i])
				p0_level_o[i] = port0_i.out[i];
			else if (!rd_pin)
				p0_level_o[i] = rd_data[i];
			else
				p0_level_o[i] = 1'b1;
		end
	end

	// an address latch chip follows the strobe, whatever is on the bus
	always_ff @(posedge clock_i)
		if (ale_i)
			lo_addr_r <= p0_level_o;
endmodule : pfsc_ext_mem

// [bench/tb.sv]
// Purpose: self-checking bench for the pin function and strobe block
// Assumes: register map and latencies as handed over with the design
// Notes: pulses are counted by a monitor and checked over fixed windows
`timescale 1ns/1ns
module tb;
	import pfsc_pkg::*;
	// ----
	// signals
	// ----
	typedef struct packed {
		logic [7:0] a;
		logic [31:0] d;
		logic [31:0] e;
		logic [1:0] r;
	} pfsc_row_t;
	logic clock_i = 1'b0;
	logic rst_b_i = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	pfsc_pins_in_t pins, pins_w;
	pfsc_mem_t mem;
	pfsc_alt_out_t alt;
	logic wd_ovf = 0, can_wake = 0, pwr_dn = 0, clr = 0;
	pfsc_pin8_t port0, port1, port2, port3, port4;
	pfsc_alt_in_t alt_in;
	logic [7:0] ext_rdata, analog, p0_lvl;
	logic ale, rst_out, rst_oe_b, conv, ea_l, can_rx, can_rst, ref_oe_b;
	logic ref_en;
	logic [31:0] c_ale, c_conv, c_tev, c_trs, c_rst;
	int num_errors = 0;
	int n_tests = 0;
	pfsc_row_t rows [7] = '{
		'{8'h00, 32'h5a, 32'h5a, RESP_OKAY},
		'{8'h0c, 32'hffff_ff3c, 32'h3c, RESP_OKAY},
		'{8'h0c, 32'hff, 32'hff, RESP_OKAY},
		'{8'h40, 32'hff, 32'h21, RESP_OKAY},
		'{8'h40, 32'h01, 32'h01, RESP_OKAY},
		'{8'h3c, 32'h55, 32'h00, RESP_SLVERR},
		'{8'h48, 32'h00, 32'h00, RESP_OKAY}};

	always #10 clock_i = ~clock_i;

	// pin levels seen by the device: drivers on ports 0, 1, 3 and the reset pin count
	always_comb
	begin
		pins_w = pins;
		pins_w.p0 = p0_lvl;
		pins_w.p1 = (port1.oe_b & pins.p1) | (~port1.oe_b & port1.out);
		pins_w.p3 = (port3.oe_b & pins.p3) | (~port3.oe_b & port3.out);
		pins_w.rst_pin = pins.rst_pin | (!rst_oe_b && rst_out);
	end

	always @(posedge clock_i)
	begin
		if (clr)
		begin
			c_ale <= 0;
			c_conv <= 0;
			c_tev <= 0;
			c_trs <= 0;
			c_rst <= 0;
		end
		else
		begin
			c_ale <= c_ale + 32'(ale);
			c_conv <= c_conv + 32'(conv);
			c_tev <= c_tev + 32'(alt_in.timer_event);
			c_trs <= c_trs + 32'(alt_in.timer_reset);
			c_rst <= c_rst + 32'(!rst_oe_b && rst_out);
		end
	end

	pfsc_top i_dut (.clock_i(clock_i), .rst_b_i(rst_b_i),
		.s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
		.s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
		.s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wvalid),
		.s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
		.s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
		.s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
		.s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
		.s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
		.s_axi_rready_i(rready), .pins_i(pins_w), .mem_i(mem),
		.alt_i(alt), .watchdog_overflow_i(wd_ovf), .can_wake_i(can_wake),
		.power_down_i(pwr_dn), .port0_o(port0), .port1_o(port1),
		.port2_o(port2), .port3_o(port3), .port4_o(port4),
		.alt_o(alt_in), .ext_rdata_o(ext_rdata),
		.analog_channels_o(analog), .ale_o(ale), .rst_pin_out_o(rst_out),
		.rst_pin_oe_b_o(rst_oe_b), .conv_start_o(conv),
		.ea_latched_o(ea_l), .can_rx_bit_o(can_rx),
		.can_reset_o(can_rst), .ref_oe_b_o(ref_oe_b),
		.ref_src_en_o(ref_en));

	pfsc_ext_mem i_mem (.clock_i(clock_i), .port0_i(port0),
		.port2_i(port2), .port3_i(port3), .ale_i(ale), .p0_level_o(p0_lvl));

	// ----
	// tasks
	// ----
	task automatic cyc(int n);
		repeat (n) @(posedge clock_i);
	endtask : cyc

	task automatic clear;
		clr <= 1'b1;
		cyc(1);
		clr <= 1'b0;
	endtask : clear

	task automatic done(string nm);
		$display("test %s finished", nm);
	endtask : done

	task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
		n_tests++;
		if (g !== e)
		begin
			num_errors++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic wr(logic [7:0] a, logic [31:0] d, logic [1:0] r);
		@(posedge clock_i);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do
		begin
			@(posedge clock_i);
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		bready <= 1'b0;
		chk("bresp", {30'h0, r}, {30'h0, bresp});
	endtask : wr

	task automatic rd(logic [7:0] a, logic [31:0] e, logic [1:0] r);
		@(posedge clock_i);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do
		begin
			@(posedge clock_i);
			if (arready)
				arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		rready <= 1'b0;
		chk("rdata", e, rdata);
		chk("rresp", {30'h0, r}, {30'h0, rresp});
	endtask : rd

	task automatic end_sim;
		$display("comparisons %0d mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : end_sim

	// ----
	// tests
	// ----
	initial
	begin
		#(20 * 6000);
		num_errors++;
		end_sim();
	end

	initial
	begin
		pins = '0;
		pins.p1 = 8'hcf;
		pins.p3 = 8'hff;
		pins.ea = 1'b1;
		pins.can_cmp = 1'b1;
		mem = '0;
		alt = '1;
		cyc(5);
		rst_b_i <= 1'b1;
		for (int i = 0; i < 5; i++)
			rd(8'(4 * i), 32'hff, RESP_OKAY);
		rd(OFS_CANCTL, 32'h01, RESP_OKAY);
		rd(OFS_STATUS, 32'h07, RESP_OKAY);
		chk("p1 float", 32'hff, {24'h0, port1.oe_b});
		done("reset");
		foreach (rows[i])
		begin
			wr(rows[i].a, rows[i].d, rows[i].r);
			rd(rows[i].a, rows[i].e, rows[i].r);
		end
		done("registers");
		clear();
		cyc(61);
		chk("ale", 32'd10, c_ale);
		clear();
		cyc(20);
		mem <= '{1'b1, 1'b1, 1'b0, 1'b0, 16'h0000, 8'h00};
		cyc(6);
		mem <= '0;
		cyc(35);
		chk("ale skip", 32'd9, c_ale);
		done("strobe");
		for (int k = 0; k < 2; k++)
		begin
			clear();
			wd_ovf <= (k == 0);
			can_wake <= (k == 1);
			cyc(1);
			wd_ovf <= 1'b0;
			can_wake <= 1'b0;
			cyc(40);
			chk("rst pulse", 32'(RST_PULSE_CYC), c_rst);
		end
		clear();
		pins.adc_start <= 1'b1;
		cyc(8);
		chk("pin start", 32'd1, c_conv);
		pins.adc_start <= 1'b0;
		wr(OFS_ADCCMD, 32'h1, RESP_OKAY);
		cyc(6);
		chk("sw start", 32'd2, c_conv);
		done("pulses");
		clear();
		pins.p1 <= 8'hf5;
		pins.p3 <= 8'h15;
		pins.p5 <= 8'h96;
		pins.can_cmp <= 1'b0;
		cyc(8);
		chk("timer event", 32'd1, c_tev);
		chk("timer reset", 32'd1, c_trs);
		chk("capture", 32'h5, {28'h0, alt_in.capture_irq});
		chk("port3 in", 32'h1a, {27'h0, alt_in.serial_rx, alt_in.irq_zero_b,
			alt_in.irq_one_b, alt_in.counter0, alt_in.counter1});
		chk("analog", 32'h96, {24'h0, analog});
		chk("can dominant", 32'h0, {31'h0, can_rx});
		rd(OFS_PIN5, 32'h96, RESP_OKAY);
		pins.can_cmp <= 1'b1;
		alt.cmp_set_reset <= 6'h2a;
		alt.cmp_toggle <= 2'b01;
		cyc(5);
		chk("can recessive", 32'h1, {31'h0, can_rx});
		chk("port4 alt", 32'h6a, {24'h0, port4.oe_b});
		wr(OFS_LATCH4, 32'h0f, RESP_OKAY);
		cyc(3);
		chk("port4 latch", 32'h0a, {24'h0, port4.oe_b});
		alt.serial_tx <= 1'b0;
		alt.rd_strobe_b <= 1'b0;
		cyc(3);
		chk("port3 alt", 32'h7d, {24'h0, port3.oe_b});
		alt <= '1;
		done("alternates");
		mem <= '{1'b1, 1'b0, 1'b1, 1'b0, 16'h1234, 8'h00};
		cyc(8);
		chk("addr hi", 32'h1200, {16'h0, port2});
		chk("addr lo", 32'h3400, {16'h0, port0});
		mem <= '{1'b1, 1'b1, 1'b0, 1'b0, 16'h1234, 8'h00};
		alt.rd_strobe_b <= 1'b0;
		cyc(6);
		chk("read data", 32'h7c, {24'h0, ext_rdata});
		chk("bus free", 32'hff, {24'h0, port0.oe_b});
		mem <= '{1'b1, 1'b1, 1'b0, 1'b1, 16'h1234, 8'ha5};
		alt.rd_strobe_b <= 1'b1;
		cyc(3);
		chk("write data", 32'ha500, {16'h0, port0});
		mem <= '0;
		done("memory");
		wr(OFS_LATCH1, 32'h3f, RESP_OKAY);
		cyc(2);
		chk("tx open drain", 32'h3f, {24'h0, port1.oe_b});
		alt.can_tx1 <= 1'b0;
		wr(OFS_CANCTL, 32'h00, RESP_OKAY);
		pwr_dn <= 1'b1;
		cyc(3);
		chk("tx drive", 32'h4, {28'h0, port1.out[7:6], port1.oe_b[7:6]});
		chk("src kept", 32'h1, {31'h0, ref_en});
		wr(OFS_CANCTL, 32'h01, RESP_OKAY);
		cyc(3);
		chk("src off", 32'h0, {31'h0, ref_en});
		pwr_dn <= 1'b0;
		wr(OFS_CANCTL, 32'h21, RESP_OKAY);
		cyc(3);
		chk("ref input", 32'h1, {31'h0, ref_oe_b});
		pins.ea <= 1'b0;
		pins.rst_pin <= 1'b1;
		cyc(6);
		pins.rst_pin <= 1'b0;
		cyc(1);
		pins.ea <= 1'b1;
		cyc(6);
		chk("ea held", 32'h0, {31'h0, ea_l});
		chk("ref output", 32'h0, {31'h0, ref_oe_b});
		chk("src on", 32'h1, {31'h0, ref_en});
		done("reference");
		wr(OFS_LATCH0, 32'h00, RESP_OKAY);
		clear();
		rst_b_i <= 1'b0;
		cyc(3);
		rst_b_i <= 1'b1;
		cyc(2);
		rd(OFS_LATCH0, 32'hff, RESP_OKAY);
		chk("can reset", 32'h1, {31'h0, can_rst});
		chk("no false event", 32'h0, c_tev);
		chk("no false reset", 32'h0, c_trs);
		done("second reset");
		end_sim();
	end
endmodule : tb
